/* File: dv/servo_stop_sequence_selector_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module servo_stop_sequence_selector_bench;
    import sssel_pkg::*;
    logic ref_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, flt = 0, aclr = 0, still = 0, ack;
    logic brk, cst, est, tle, dclr, dhold, sact, pw, sv, pt, ms;
    logic fic = 0;
    logic [7:0] adr = 0;
    logic [31:0] dw = 0, dr, rd;
    logic [3:0] cmd = 4'hC;
    logic [15:0] tlv, tq;
    logic [1:0] cm;
    int err_count = 0, tests_run = 0, seed = 32'h72B7, n;
    sssel_host_model u_host (.ref_clk(ref_clk), .cmd(cmd), .main_power_ok(pw),
        .servo_enable_input(sv), .positive_travel_inhibit(pt), .mode_switch_input(ms));
    sssel_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .wb_adr_i(adr), .wb_dat_i(dw),
        .wb_dat_o(dr), .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .main_power_ok(pw), .servo_enable_input(sv), .positive_travel_inhibit(pt),
        .negative_travel_inhibit(1'b0), .mode_switch_input(ms), .protective_fault(flt),
        .fault_immediate_capable(fic), .alarm_clear(aclr), .motor_standstill(still),
        .short_circuit_brake(brk), .coast_enable(cst), .emergency_stop_active(est),
        .torque_limit_enable(tle), .torque_limit_value(tlv), .deviation_clear(dclr),
        .deviation_hold(dhold), .stop_active(sact), .control_mode(cm));
    // Clock generation
    initial forever #50 ref_clk = ~ref_clk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Classic single Wishbone cycle, bounded wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dw <= d;
        for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge ref_clk);
        if (k == 20) begin err_count++; tally_and_finish(); end
        rd = dr;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    // Expected {brake, coast, estop, clear, hold}
    function automatic logic [4:0] exp_stop(input logic [3:0] s, input logic st);
        if (s >= 8) return {!st ? 3'b001 : (s[0] ? 3'b010 : 3'b100), 2'b10};
        return {((st ? s[1] : s[0]) ? 3'b010 : 3'b100), s < 4, s >= 4};
    endfunction
    function automatic logic [1:0] exp_mode(input logic [2:0] m, input logic sw);
        case (m)
            3: return sw ? 2'd0 : 2'd1;
            4: return sw ? 2'd0 : 2'd2;
            5: return sw ? 2'd1 : 2'd2;
            6: return 2'd3;
            7: return 2'd0;
            default: return m[1:0];
        endcase
    endfunction
    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1;
        wb(0, 8'h08, 0); chk(rd, 0);
        wb(0, 8'hF0, 0); chk(rd, 0);
        tq = 16'($random(seed));
        wb(1, 8'h10, {16'h0, tq});
        // Power loss then servo disable, settings 0-9, moving and at rest
        for (int i = 0; i < 40; i++) begin
            int t, s, st;
            t = i / 20;
            s = (i / 2) % 10;
            st = i % 2;
            wb(1, t ? 8'h04 : 8'h00, s);
            cmd <= t ? 4'h8 : 4'h4;
            still <= st[0];
            repeat (5) @(posedge ref_clk);
            chk({brk, cst, est, dclr, dhold}, exp_stop(s[3:0], st[0]));
            if (s >= 8 && st == 0) chk({tle, tlv}, {1'b1, tq});
            if (s == 9 && st == 1) begin
                wb(0, 8'h18, 0);
                chk(rd[27:16], t ? 12'h506 : 12'h507);
            end
            cmd <= 4'hC;
            repeat (5) @(posedge ref_clk);
            chk(sact, 0);
        end
        $display("stop table test done");
        // Fault over power loss, then behaviours A and B, then alarm clear
        wb(1, 8'h08, 0);
        cmd <= 4'h4;
        still <= 0;
        flt <= 1;
        repeat (5) @(posedge ref_clk);
        wb(0, 8'h18, 0);
        chk(rd[2:0], 1);
        chk({brk, dhold}, 2'b11);
        wb(1, 8'h08, 4);
        fic <= 1;
        repeat (2) @(posedge ref_clk);
        chk({est, dhold}, 2'b11);
        fic <= 0;
        cmd <= 4'hC;
        repeat (5) @(posedge ref_clk);
        chk({brk, est, dhold}, 3'b101);
        flt <= 0;
        aclr <= 1;
        n = 0;
        repeat (6) begin
            @(posedge ref_clk);
            aclr <= 0;
            #1 n += dclr;
        end
        chk(n, 1);
        $display("fault test done");
        for (int m = 0; m < 8; m++) for (int sw = 0; sw < 2; sw++) begin
            wb(1, 8'h14, m);
            cmd <= {3'b110, sw[0]};
            repeat (5) @(posedge ref_clk);
            chk(cm, exp_mode(m[2:0], sw[0]));
        end
        $display("mode test done");
        wb(1, 8'h0C, 2);
        cmd <= 4'hE;
        repeat (5) @(posedge ref_clk);
        chk({brk, est}, 2'b10);
        rst_n <= 0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1;
        repeat (6) @(posedge ref_clk);
        chk({est, tle}, 2'b11);
        $display("over-travel test done");
        tally_and_finish();
    end
endmodule // servo_stop_sequence_selector_bench
`default_nettype wire

/* File: dv/sssel_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sssel_host_model (
    input wire logic ref_clk,
    input wire logic [3:0] cmd,
    output logic main_power_ok,
    output logic servo_enable_input,
    output logic positive_travel_inhibit,
    output logic mode_switch_input
);
    // Pins follow the host command, registered on each rising clock edge
    always_ff @(posedge ref_clk) begin
        {main_power_ok, servo_enable_input, positive_travel_inhibit, mode_switch_input}
            <= cmd;
    end
endmodule // sssel_host_model
`default_nettype wire

/* File: src/sssel_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Carries the chosen setting to the decoders and their verdicts back
interface sssel_if;
    import sssel_pkg::*;
    logic [3:0] setting;
    sssel_cause_t cause;
    logic fault_immediate;
    logic standstill;
    sssel_act_t act;
    logic clear_dev;
    logic [2:0] mode_sel;
    logic mode_switch;
    sssel_mode_t mode_eff;

    modport top (output setting, cause, fault_immediate, standstill, mode_sel, mode_switch,
                 input act, clear_dev, mode_eff);
    modport stop (input setting, cause, fault_immediate, standstill, output act, clear_dev);
    modport mode (input mode_sel, mode_switch, output mode_eff);
endinterface
`default_nettype wire

/* File: src/sssel_mode_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module sssel_mode_decode
    import sssel_pkg::*;
(
    sssel_if.mode bus
);
    // Single modes map directly, pairs follow the switch input
    always_comb begin
        case (bus.mode_sel)
            3'h0: bus.mode_eff = SSSEL_M_POS;
            3'h1: bus.mode_eff = SSSEL_M_VEL;
            3'h2: bus.mode_eff = SSSEL_M_TRQ;
            3'h3: bus.mode_eff = bus.mode_switch ? SSSEL_M_POS : SSSEL_M_VEL;
            3'h4: bus.mode_eff = bus.mode_switch ? SSSEL_M_POS : SSSEL_M_TRQ;
            3'h5: bus.mode_eff = bus.mode_switch ? SSSEL_M_VEL : SSSEL_M_TRQ;
            3'h6: bus.mode_eff = SSSEL_M_FULL;
            default: bus.mode_eff = SSSEL_M_POS;
        endcase
    end
endmodule // sssel_mode_decode
`default_nettype wire

/* File: src/sssel_pkg.sv */
// What this block does
// - Power loss: 0-3 clear, 4-7 hold, bits pick coast
// - Power loss 8/9: emergency stop, then brake/coast
// - Servo disable uses same ten-value stop encoding
// - Settings 8/9 limit torque to emergency value
// - Fault 4-7: A if immediate-capable, else B
// - Fault stop clears deviation when alarm clears
// - Over-travel setting 2 limits deceleration torque
// - Over-travel setting adopted only after power-on
// - Control mode: 0-2 single, 3-5 pairs, 6 full-closed
// - Pair mode: switch on first, off second
// - Settings identified by class digit and index
// - Brake engages only on the four triggers
package sssel_pkg;

    // Register byte offsets
    localparam logic [7:0] SSSEL_OFS_PWR = 8'h00;
    localparam logic [7:0] SSSEL_OFS_SRV = 8'h04;
    localparam logic [7:0] SSSEL_OFS_FLT = 8'h08;
    localparam logic [7:0] SSSEL_OFS_OT = 8'h0C;
    localparam logic [7:0] SSSEL_OFS_TRQ = 8'h10;
    localparam logic [7:0] SSSEL_OFS_MODE = 8'h14;
    localparam logic [7:0] SSSEL_OFS_STAT = 8'h18;
    localparam logic [7:0] SSSEL_OFS_OTACT = 8'h1C;

    // Values after reset
    localparam logic [3:0] SSSEL_RST_SEL = 4'h0;
    localparam logic [2:0] SSSEL_RST_MODE = 3'h0;
    localparam logic [15:0] SSSEL_RST_TRQ = 16'h0000;

    // Status register field positions
    localparam int unsigned SSSEL_ST_CAUSE = 0;
    localparam int unsigned SSSEL_ST_ACT = 3;
    localparam int unsigned SSSEL_ST_STILL = 5;
    localparam int unsigned SSSEL_ST_MODE = 6;
    localparam int unsigned SSSEL_ST_FLT = 8;
    localparam int unsigned SSSEL_ST_ID = 16;

    // Stop setting codes with special meaning
    localparam logic [3:0] SSSEL_SEL_ESTOP_BRAKE = 4'h8;
    localparam logic [3:0] SSSEL_SEL_ESTOP_COAST = 4'h9;
    localparam logic [3:0] SSSEL_SEL_OT_ESTOP = 4'h2;

    // Setting identities as class digit and two-digit index
    localparam logic [3:0] SSSEL_CLS_BASIC = 4'h0;
    localparam logic [3:0] SSSEL_CLS_ENH = 4'h5;
    localparam logic [7:0] SSSEL_IDX_MODE = 8'h01;
    localparam logic [7:0] SSSEL_IDX_OT = 8'h05;
    localparam logic [7:0] SSSEL_IDX_SRV = 8'h06;
    localparam logic [7:0] SSSEL_IDX_PWR = 8'h07;
    localparam logic [7:0] SSSEL_IDX_FLT = 8'h10;

    typedef enum logic [1:0] {SSSEL_ACT_NONE, SSSEL_ACT_BRAKE, SSSEL_ACT_COAST, SSSEL_ACT_ESTOP}
        sssel_act_t;
    typedef enum logic [2:0] {SSSEL_C_NONE, SSSEL_C_FLT, SSSEL_C_PWR, SSSEL_C_OT, SSSEL_C_SRV}
        sssel_cause_t;
    typedef enum logic [1:0] {SSSEL_M_POS, SSSEL_M_VEL, SSSEL_M_TRQ, SSSEL_M_FULL} sssel_mode_t;
    typedef enum logic [1:0] {SSSEL_S_IDLE, SSSEL_S_DECEL, SSSEL_S_STILL} sssel_state_t;

    // Packs a class digit and index into one identity word
    function automatic logic [11:0] sssel_setting_id(input logic [3:0] cls,
                                                     input logic [7:0] idx);
        sssel_setting_id = {cls, idx};
    endfunction

endpackage

/* File: src/sssel_stop_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module sssel_stop_decode
    import sssel_pkg::*;
(
    sssel_if.stop bus
);
    // Ten-value table: brake or coast per phase, or emergency stop
    function automatic sssel_act_t phase_act(input logic [3:0] sel, input logic still);
        if (sel == SSSEL_SEL_ESTOP_BRAKE || sel == SSSEL_SEL_ESTOP_COAST) begin
            phase_act = still ? (sel[0] ? SSSEL_ACT_COAST : SSSEL_ACT_BRAKE) : SSSEL_ACT_ESTOP;
        end else if (sel > SSSEL_SEL_ESTOP_COAST) begin
            phase_act = SSSEL_ACT_BRAKE;
        end else begin
            phase_act = (still ? sel[1] : sel[0]) ? SSSEL_ACT_COAST : SSSEL_ACT_BRAKE;
        end
    endfunction

    // Action and counter verdict for the winning trigger
    always_comb begin
        bus.act = SSSEL_ACT_NONE;
        bus.clear_dev = 1'b0;
        case (bus.cause)
            SSSEL_C_PWR, SSSEL_C_SRV: begin
                bus.act = phase_act(bus.setting, bus.standstill);
                bus.clear_dev = (bus.setting < 4'h4) || (bus.setting == SSSEL_SEL_ESTOP_BRAKE)
                    || (bus.setting == SSSEL_SEL_ESTOP_COAST);
            end
            SSSEL_C_FLT: begin
                if (bus.setting[3:2] == 2'b01 && bus.fault_immediate) begin
                    // Behaviour A: torque-limited stop, then bit 1 picks rest state
                    bus.act = bus.standstill ? (bus.setting[1] ? SSSEL_ACT_COAST : SSSEL_ACT_BRAKE)
                        : SSSEL_ACT_ESTOP;
                end else begin
                    bus.act = phase_act({2'b00, bus.setting[1:0]}, bus.standstill);
                end
            end
            SSSEL_C_OT: begin
                if (bus.standstill) begin
                    bus.act = SSSEL_ACT_NONE;
                end else if (bus.setting == SSSEL_SEL_OT_ESTOP) begin
                    bus.act = SSSEL_ACT_ESTOP;
                end else begin
                    bus.act = bus.setting[0] ? SSSEL_ACT_COAST : SSSEL_ACT_BRAKE;
                end
            end
            default: begin
                bus.act = SSSEL_ACT_NONE;
            end
        endcase
    end
endmodule // sssel_stop_decode
`default_nettype wire

/* File: src/sssel_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sssel_top
    import sssel_pkg::*;
#(
    parameter int unsigned TORQUE_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic main_power_ok,
    input wire logic servo_enable_input,
    input wire logic positive_travel_inhibit,
    input wire logic negative_travel_inhibit,
    input wire logic mode_switch_input,
    input wire logic protective_fault,
    input wire logic fault_immediate_capable,
    input wire logic alarm_clear,
    input wire logic motor_standstill,
    output logic short_circuit_brake,
    output logic coast_enable,
    output logic emergency_stop_active,
    output logic torque_limit_enable,
    output logic [TORQUE_W-1:0] torque_limit_value,
    output logic deviation_clear,
    output logic deviation_hold,
    output logic stop_active,
    output logic [1:0] control_mode
);
    sssel_if dec ();

    // Pin synchronisers: power, enable, two inhibits, mode switch
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic pwr_ok;
    logic srv_en;
    logic ot_hit;
    logic mode_sw;

    // Software settings
    logic [3:0] pwr_sel_reg;
    logic [3:0] srv_sel_reg;
    logic [3:0] flt_sel_reg;
    logic [3:0] ot_pending_reg = SSSEL_RST_SEL;
    logic [3:0] ot_active_reg;
    logic [TORQUE_W-1:0] trq_reg;
    logic [2:0] mode_sel_reg;

    // Block state
    logic fault_latched_reg;
    sssel_state_t state_reg;
    sssel_state_t state_next;
    sssel_cause_t cause;
    sssel_cause_t cause_reg;
    sssel_act_t act_reg;
    logic [11:0] id_reg;
    logic [11:0] id_next;
    logic alarm_release;

    // Bus decode
    logic bus_req;
    logic bus_wr;
    logic [31:0] rd_next;
    logic [31:0] stat_word;

    // Byte-lane merge of a write into a register's old value
    function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            lane_merge[i*8 +: 8] = sel[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
        end
    endfunction

    // Two flip-flops before logic reads the power, enable, inhibit or mode switch pins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
        end else if (ce) begin
            pin_meta_reg <= {mode_switch_input, negative_travel_inhibit,
                             positive_travel_inhibit, servo_enable_input, main_power_ok};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign pwr_ok = pin_sync_reg[0];
    assign srv_en = pin_sync_reg[1];
    assign ot_hit = pin_sync_reg[2] | pin_sync_reg[3];
    assign mode_sw = pin_sync_reg[4];

    // Classic Wishbone: one registered ack per request
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Write lands on the edge where the master sees ack high
    assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= bus_req;
        end
    end

    // Writable settings, byte lanes honoured
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pwr_sel_reg <= SSSEL_RST_SEL;
            srv_sel_reg <= SSSEL_RST_SEL;
            flt_sel_reg <= SSSEL_RST_SEL;
            trq_reg <= TORQUE_W'(SSSEL_RST_TRQ);
            mode_sel_reg <= SSSEL_RST_MODE;
        end else if (ce && bus_wr) begin
            case (wb_adr_i)
                SSSEL_OFS_PWR: pwr_sel_reg <= 4'(lane_merge(32'(pwr_sel_reg), wb_dat_i, wb_sel_i));
                SSSEL_OFS_SRV: srv_sel_reg <= 4'(lane_merge(32'(srv_sel_reg), wb_dat_i, wb_sel_i));
                SSSEL_OFS_FLT: flt_sel_reg <= 4'(lane_merge(32'(flt_sel_reg), wb_dat_i, wb_sel_i));
                SSSEL_OFS_TRQ: trq_reg <= TORQUE_W'(lane_merge(32'(trq_reg), wb_dat_i, wb_sel_i));
                SSSEL_OFS_MODE: mode_sel_reg <= 3'(lane_merge(32'(mode_sel_reg), wb_dat_i,
                                                              wb_sel_i));
                default: ;
            endcase
        end
    end

    // Stored over-travel value survives the control reset like a saved parameter
    always_ff @(posedge ref_clk) begin
        if (ce && bus_wr && wb_adr_i == SSSEL_OFS_OT) begin
            ot_pending_reg <= 4'(lane_merge(32'(ot_pending_reg), wb_dat_i, wb_sel_i));
        end
    end

    // Working copy taken only while control power comes up
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ot_active_reg <= ot_pending_reg;
        end
    end

    // Fault stays latched until the alarm is cleared with the fault gone
    assign alarm_release = fault_latched_reg & alarm_clear & ~protective_fault;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fault_latched_reg <= 1'b0;
        end else if (ce) begin
            if (protective_fault) begin
                fault_latched_reg <= 1'b1;
            end else if (alarm_release) begin
                fault_latched_reg <= 1'b0;
            end
        end
    end

    // Winning trigger and the setting that governs it
    always_comb begin
        cause = SSSEL_C_NONE;
        dec.setting = SSSEL_RST_SEL;
        id_next = 12'h000;
        if (fault_latched_reg) begin
            cause = SSSEL_C_FLT;
            dec.setting = flt_sel_reg;
            id_next = sssel_setting_id(SSSEL_CLS_ENH, SSSEL_IDX_FLT);
        end else if (!pwr_ok) begin
            cause = SSSEL_C_PWR;
            dec.setting = pwr_sel_reg;
            id_next = sssel_setting_id(SSSEL_CLS_ENH, SSSEL_IDX_PWR);
        end else if (ot_hit) begin
            cause = SSSEL_C_OT;
            dec.setting = ot_active_reg;
            id_next = sssel_setting_id(SSSEL_CLS_ENH, SSSEL_IDX_OT);
        end else if (!srv_en) begin
            cause = SSSEL_C_SRV;
            dec.setting = srv_sel_reg;
            id_next = sssel_setting_id(SSSEL_CLS_ENH, SSSEL_IDX_SRV);
        end
    end

    assign dec.cause = cause;
    assign dec.fault_immediate = fault_immediate_capable;
    assign dec.standstill = motor_standstill;
    assign dec.mode_sel = mode_sel_reg;
    assign dec.mode_switch = mode_sw;

    sssel_stop_decode u_stop (
        .bus(dec.stop)
    );

    sssel_mode_decode u_mode (
        .bus(dec.mode)
    );

    // Stop sequence: deceleration, then standstill
    always_comb begin
        case (state_reg)
            SSSEL_S_IDLE: state_next = (cause != SSSEL_C_NONE) ? SSSEL_S_DECEL : SSSEL_S_IDLE;
            SSSEL_S_DECEL: begin
                if (cause == SSSEL_C_NONE) begin
                    state_next = SSSEL_S_IDLE;
                end else begin
                    state_next = motor_standstill ? SSSEL_S_STILL : SSSEL_S_DECEL;
                end
            end
            SSSEL_S_STILL: state_next = (cause != SSSEL_C_NONE) ? SSSEL_S_STILL : SSSEL_S_IDLE;
            default: state_next = SSSEL_S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= SSSEL_S_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Drive outputs from the decoded action
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cause_reg <= SSSEL_C_NONE;
            act_reg <= SSSEL_ACT_NONE;
            id_reg <= 12'h000;
            short_circuit_brake <= 1'b0;
            coast_enable <= 1'b0;
            emergency_stop_active <= 1'b0;
            torque_limit_enable <= 1'b0;
            stop_active <= 1'b0;
        end else if (ce) begin
            cause_reg <= cause;
            act_reg <= dec.act;
            id_reg <= id_next;
            short_circuit_brake <= (cause != SSSEL_C_NONE)
                && (dec.act == SSSEL_ACT_BRAKE);
            coast_enable <= dec.act == SSSEL_ACT_COAST;
            emergency_stop_active <= dec.act == SSSEL_ACT_ESTOP;
            torque_limit_enable <= dec.act == SSSEL_ACT_ESTOP;
            stop_active <= cause != SSSEL_C_NONE;
        end
    end

    // Emergency torque ceiling follows the setting
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            torque_limit_value <= TORQUE_W'(SSSEL_RST_TRQ);
        end else if (ce) begin
            torque_limit_value <= trq_reg;
        end
    end

    // Deviation counter: clear or hold per setting, fault clears at alarm release
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            deviation_clear <= 1'b0;
            deviation_hold <= 1'b0;
        end else if (ce) begin
            if (cause == SSSEL_C_FLT) begin
                deviation_clear <= alarm_release;
                deviation_hold <= ~alarm_release;
            end else begin
                deviation_clear <= (cause != SSSEL_C_NONE) && dec.clear_dev;
                deviation_hold <= (cause != SSSEL_C_NONE) && !dec.clear_dev;
            end
        end
    end

    // Effective control mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            control_mode <= 2'(SSSEL_M_POS);
        end else if (ce) begin
            control_mode <= 2'(dec.mode_eff);
        end
    end

    // Status word
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[SSSEL_ST_CAUSE +: 3] = 3'(cause_reg);
        stat_word[SSSEL_ST_ACT +: 2] = 2'(act_reg);
        stat_word[SSSEL_ST_STILL] = state_reg == SSSEL_S_STILL;
        stat_word[SSSEL_ST_MODE +: 2] = control_mode;
        stat_word[SSSEL_ST_FLT] = fault_latched_reg;
        stat_word[SSSEL_ST_ID +: 12] = id_reg;
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (wb_adr_i)
            SSSEL_OFS_PWR: rd_next = 32'(pwr_sel_reg);
            SSSEL_OFS_SRV: rd_next = 32'(srv_sel_reg);
            SSSEL_OFS_FLT: rd_next = 32'(flt_sel_reg);
            SSSEL_OFS_OT: rd_next = 32'(ot_pending_reg);
            SSSEL_OFS_TRQ: rd_next = 32'(trq_reg);
            SSSEL_OFS_MODE: rd_next = 32'(mode_sel_reg);
            SSSEL_OFS_STAT: rd_next = stat_word;
            SSSEL_OFS_OTACT: rd_next = 32'(ot_active_reg);
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce && bus_req) begin
            wb_dat_o <= rd_next;
        end
    end

    // Checks on the stop outputs against their causes, the over-travel working copy, pair mode and fault priority
    AST_BRAKE_NEEDS_TRIGGER: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && cause == SSSEL_C_NONE |=> !short_circuit_brake && !stop_active)
        else $error("brake engaged with no stop trigger");

    AST_PWR_ESTOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && cause == SSSEL_C_PWR && pwr_sel_reg == 4'h8 && !motor_standstill
        |=> emergency_stop_active && torque_limit_enable && deviation_clear)
        else $error("power loss setting 8 did not start emergency stop");

    AST_PWR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && cause == SSSEL_C_PWR && pwr_sel_reg inside {[4'h4:4'h7]}
        |=> deviation_hold && !deviation_clear)
        else $error("power loss setting 4-7 did not hold deviation");

    AST_SRV_COAST: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && cause == SSSEL_C_SRV && srv_sel_reg == 4'h1 && !motor_standstill
        |=> coast_enable && !short_circuit_brake)
        else $error("servo disable setting 1 did not coast while decelerating");

    AST_ESTOP_TORQUE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && emergency_stop_active
        |-> torque_limit_enable && torque_limit_value == $past(trq_reg))
        else $error("emergency stop without its torque ceiling");

    AST_FAULT_A: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && cause == SSSEL_C_FLT && flt_sel_reg inside {[4'h4:4'h7]}
        && fault_immediate_capable && !motor_standstill |=> emergency_stop_active)
        else $error("immediate-capable fault did not stop at once");

    AST_ALARM_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && fault_latched_reg && alarm_clear && !protective_fault
        |=> deviation_clear ##1 (!ce || !fault_latched_reg))
        else $error("alarm clear did not clear the deviation counter");

    AST_OT_TORQUE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && cause == SSSEL_C_OT && ot_active_reg == 4'h2 && !motor_standstill
        |=> torque_limit_enable)
        else $error("over-travel setting 2 did not limit torque");

    AST_OT_FROZEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rst_n |=> $stable(ot_active_reg))
        else $error("over-travel setting changed within a session");

    AST_MODE_PAIR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && mode_sel_reg == 3'h4 |=> control_mode == ($past(mode_sw) ? 2'(SSSEL_M_POS)
                                                        : 2'(SSSEL_M_TRQ)))
        else $error("position/torque pair ignored the mode switch");

    AST_FAULT_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ce && fault_latched_reg |=> cause_reg == SSSEL_C_FLT
        && id_reg == sssel_setting_id(SSSEL_CLS_ENH, SSSEL_IDX_FLT))
        else $error("fault did not take priority");

endmodule // sssel_top
`default_nettype wire
